/* shared/silpod_pkg.sv */
// Shared constants for the serial-in latched parallel-out driver
`default_nettype none
package silpod_pkg;
    // Number of shift stages and output latch bits
    localparam int          STAGES        = 8;
    // Depth of the snapshot buffer between the shift stages and the latch
    localparam int          BUF_DEPTH     = 2;
    // Reset contents of the shift stages and of the output latch
    localparam logic [7:0]  SHIFT_RST_VAL = 8'h00;
    localparam logic [7:0]  LATCH_RST_VAL = 8'h00;
    // Number of input pins passed through the synchroniser
    localparam int          PIN_COUNT     = 6;
    // Pin positions in the synchronised pin vector
    localparam int          PIN_DATA      = 0;
    localparam int          PIN_SHIFT     = 1;
    localparam int          PIN_LATCH     = 2;
    localparam int          PIN_CLEAR_N   = 3;
    localparam int          PIN_OE_N      = 4;
    localparam int          PIN_HOLD      = 5;
    // Synchroniser reset levels: clocks, data, clear and hold low, enable off
    localparam logic [5:0]  PIN_RST_VAL   = 6'h10;
endpackage
`default_nettype wire

/* core/silpod_sync.sv */
// Three-stage pin synchroniser with agreement filter, one lane per bit
`default_nettype none
module silpod_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q
);
    import silpod_pkg::*;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic s1;
            logic s2;
            logic s3;
            logic next_q;

            // Accept a new level only once stages two and three agree
            always_comb begin
                next_q = (s2 == s3) ? s3 : q[i];
            end

            // Stage one feeds stage two only
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1   <= RST_VAL[i];
                    s2   <= RST_VAL[i];
                    s3   <= RST_VAL[i];
                    q[i] <= RST_VAL[i];
                end else begin
                    s1   <= d_in[i];
                    s2   <= s1;
                    s3   <= s2;
                    q[i] <= next_q;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* core/silpod_buf.sv */
// Small snapshot buffer with valid and ready on both sides
`default_nettype none
module silpod_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import silpod_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign out_data = mem[rd_ptr];

    // Pointer and fill level bookkeeping; ready and valid are registered
    always_comb begin
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : PW'(wr_ptr + 1'b1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : PW'(rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= (next_count != FULL);
            out_valid <= (next_count != '0);
        end
    end

    // Storage is written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* core/silpod_top.sv */
// Serial-in shift stages, buffered output latch and three-state outputs
//
// What this block does
// - Shift edge loads serial input into stage one, others move one stage up.
// - Shift and latch clocks are independent; each acts on rising edge only.
// - Every bit has a separate shift element and a latch element.
// - Latch edge copies all stages at once; latch drives the parallel outputs.
// - Cascade output always shows the final shift stage for chaining.
// - With both clocks tied, outputs show shift contents one clock behind.
// - Clear input low zeroes shift stages and cascade; latch keeps contents.
// - Enable input high floats all parallel outputs; cascade keeps driving.
// - Output enable changes never disturb shifting or stage contents.
`default_nettype none
module silpod_top #(
    parameter int STAGES    = silpod_pkg::STAGES,
    parameter int BUF_DEPTH = silpod_pkg::BUF_DEPTH
) (
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    input  wire logic              SERIAL_DATA_IN,
    input  wire logic              SHIFT_CLOCK_IN,
    input  wire logic              LATCH_CLOCK_IN,
    input  wire logic              CLEAR_N,
    input  wire logic              OUT_EN_N,
    input  wire logic              UPDATE_HOLD,
    output logic      [STAGES-1:0] PAR_OUT,
    output logic      [STAGES-1:0] PAR_OE,
    output logic                   CASCADE_SERIAL_OUT,
    output logic                   LATCH_READY
);
    import silpod_pkg::*;

    // Synchronised pin vector and its named lanes
    logic [PIN_COUNT-1:0] pins;
    logic                 data_lvl;
    logic                 shift_lvl;
    logic                 latch_lvl;
    logic                 clear_n_lvl;
    logic                 oe_n_lvl;
    logic                 hold_lvl;

    // Edge detector state for the two clock pins
    logic                 shift_prev;
    logic                 latch_prev;
    logic                 next_shift_prev;
    logic                 next_latch_prev;
    logic                 shift_rise;
    logic                 latch_rise;

    // Shift elements, latch elements and what feeds each stage
    logic [STAGES-1:0]    shift_stage;
    logic [STAGES-1:0]    latch_stage;
    logic [STAGES-1:0]    stage_feed;

    // Output enable, one flop per parallel output
    logic [STAGES-1:0]    oe_vec;

    // Snapshot buffer handshake between shift stages and latch
    logic                 buf_in_ready;
    logic                 buf_out_valid;
    logic [STAGES-1:0]    buf_out_data;
    logic                 buf_out_ready;
    logic                 buf_pop;

    // All pins come from outside the clock domain
    silpod_sync #(
        .W       (PIN_COUNT),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (RST_N),
        .d_in  ({UPDATE_HOLD, OUT_EN_N, CLEAR_N,
                 LATCH_CLOCK_IN, SHIFT_CLOCK_IN, SERIAL_DATA_IN}),
        .q     (pins)
    );

    // Named lanes of the synchronised pins
    assign data_lvl    = pins[PIN_DATA];
    assign shift_lvl   = pins[PIN_SHIFT];
    assign latch_lvl   = pins[PIN_LATCH];
    assign clear_n_lvl = pins[PIN_CLEAR_N];
    assign oe_n_lvl    = pins[PIN_OE_N];
    assign hold_lvl    = pins[PIN_HOLD];

    assign shift_rise = shift_lvl && !shift_prev;
    assign latch_rise = latch_lvl && !latch_prev;

    // Edge history next values, each clock pin kept apart
    always_comb begin
        next_shift_prev = shift_lvl;
        next_latch_prev = latch_lvl;
    end

    // Edge history starts at the lane's reset level: no false edge
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_prev <= PIN_RST_VAL[PIN_SHIFT];
            latch_prev <= PIN_RST_VAL[PIN_LATCH];
        end else begin
            shift_prev <= next_shift_prev;
            latch_prev <= next_latch_prev;
        end
    end

    // Stage zero takes the data pin, every other stage the one below
    assign stage_feed = {shift_stage[STAGES-2:0], data_lvl};

    // One slice per bit: shift element, latch element, output enable
    genvar b;
    generate
        for (b = 0; b < STAGES; b++) begin : g_bit
            logic next_shift_bit;
            logic next_latch_bit;
            logic next_oe_bit;

            // Shift element next value
            always_comb begin
                next_shift_bit = shift_stage[b];
                if (!clear_n_lvl) begin
                    next_shift_bit = SHIFT_RST_VAL[b];
                end else if (shift_rise) begin
                    next_shift_bit = stage_feed[b];
                end
            end

            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    shift_stage[b] <= SHIFT_RST_VAL[b];
                end else begin
                    shift_stage[b] <= next_shift_bit;
                end
            end

            // Latch element next value
            always_comb begin
                next_latch_bit = latch_stage[b];
                if (buf_pop) begin
                    next_latch_bit = buf_out_data[b];
                end
            end

            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    latch_stage[b] <= LATCH_RST_VAL[b];
                end else begin
                    latch_stage[b] <= next_latch_bit;
                end
            end

            // Output enable next value
            always_comb begin
                next_oe_bit = !oe_n_lvl;
            end

            // Enable flop; outputs float until the enable pin is seen
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    oe_vec[b] <= 1'b0;
                end else begin
                    oe_vec[b] <= next_oe_bit;
                end
            end
        end
    endgenerate

    // Hold keeps snapshots queued instead of reaching the latch
    assign buf_out_ready = !hold_lvl;
    assign buf_pop       = buf_out_valid && buf_out_ready;

    // Snapshots wait here while the output side is held
    // parallel snapshot on latch edge
    silpod_buf #(
        .WIDTH (STAGES),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .in_valid  (latch_rise),
        .in_ready  (buf_in_ready),
        .in_data   (shift_stage),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    assign CASCADE_SERIAL_OUT = shift_stage[STAGES-1];

    // Outputs come straight from their flops
    assign PAR_OUT     = latch_stage;
    assign PAR_OE      = oe_vec;
    assign LATCH_READY = buf_in_ready; // Registered inside the buffer
endmodule
`default_nettype wire

/* bench/silpod_assertions.sv */
// Checker for the shift, latch and enable paths of the driver
`default_nettype none
module silpod_assertions #(
    parameter int STAGES = 8
) (
    input wire logic              MCLK,
    input wire logic              RST_N,
    input wire logic              SHIFT_CLOCK_IN,
    input wire logic              LATCH_CLOCK_IN,
    input wire logic              CLEAR_N,
    input wire logic              OUT_EN_N,
    input wire logic              UPDATE_HOLD,
    input wire logic [STAGES-1:0] PAR_OUT,
    input wire logic [STAGES-1:0] PAR_OE,
    input wire logic              CASCADE_SERIAL_OUT,
    input wire logic              LATCH_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, reset aborts every attempt
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    chk_oe_float: assert property (OUT_EN_N [*7] |-> PAR_OE == '0)
        else $error("outputs driven while disabled");
    chk_oe_drive: assert property (!OUT_EN_N [*7] |-> PAR_OE == '1)
        else $error("outputs floating while enabled");
    chk_oe_uniform: assert property (PAR_OE == '0 || PAR_OE == '1)
        else $error("enable bits disagree");
    chk_clear_cascade: assert property (!CLEAR_N [*6] |->
        !CASCADE_SERIAL_OUT) else $error("cascade not cleared");
    chk_cascade_steady: assert property ((CLEAR_N &&
        $stable(SHIFT_CLOCK_IN)) [*8] |-> $stable(CASCADE_SERIAL_OUT))
        else $error("cascade moved without shift edge");
    chk_cascade_cause: assert property ($rose(CASCADE_SERIAL_OUT) |->
        $past(SHIFT_CLOCK_IN, 4)) else $error("cascade rose unprompted");
    chk_latch_steady: assert property ((!LATCH_CLOCK_IN &&
        !UPDATE_HOLD) [*8] |=> $stable(PAR_OUT))
        else $error("latch moved without latch edge");
    chk_ready_free: assert property (!UPDATE_HOLD [*8] |-> LATCH_READY)
        else $error("buffer not drained");
endmodule
bind silpod_top silpod_assertions #(.STAGES(STAGES)) u_chk (
    .MCLK(MCLK), .RST_N(RST_N), .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN),
    .LATCH_CLOCK_IN(LATCH_CLOCK_IN), .CLEAR_N(CLEAR_N), .OUT_EN_N(OUT_EN_N),
    .UPDATE_HOLD(UPDATE_HOLD), .PAR_OUT(PAR_OUT), .PAR_OE(PAR_OE),
    .CASCADE_SERIAL_OUT(CASCADE_SERIAL_OUT), .LATCH_READY(LATCH_READY));
`default_nettype wire

/* bench/silpod_host.sv */
// Host controller model driving data, clocks, clear and enable pins
`default_nettype none
module silpod_host (
    input  wire logic clk,
    output logic      data,
    output logic      shift_clk,
    output logic      latch_clk,
    output logic      clear_n,
    output logic      oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pin levels
    initial begin
        data = 1'h0;
        shift_clk = 1'h0;
        latch_clk = 1'h0;
        clear_n = 1'h1;
        oe_n = 1'h0;
    end
    // data set up, clock pulses, data held then flipped
    task automatic pulse(input logic d, input logic s, input logic l);
        @(posedge clk) data <= d;
        repeat (4) @(posedge clk);
        shift_clk <= s;
        latch_clk <= l;
        repeat (4) @(posedge clk);
        shift_clk <= 1'h0;
        latch_clk <= 1'h0;
        repeat (4) @(posedge clk);
        data <= ~d; // Stale data is not kept
    endtask
    // Level pins, then time to pass the pin filter
    task automatic pins(input logic clr, input logic en);
        @(posedge clk) clear_n <= clr;
        oe_n <= en;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* bench/silpod_top_tb.sv */
// Self-checking bench for the serial-in latched parallel-out driver
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module silpod_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import silpod_pkg::*;
    logic              mclk, rst_n, hold, sd, sck, lck, clr_n, oe_n;
    logic              casc, rdy;
    logic [STAGES-1:0] par, oe;
    int                err_count, n_checks, cyc, sr, lat;
    int                q[$];
    silpod_host host (.clk(mclk), .data(sd), .shift_clk(sck),
        .latch_clk(lck), .clear_n(clr_n), .oe_n(oe_n));
    silpod_top dut (.MCLK(mclk), .RST_N(rst_n), .SERIAL_DATA_IN(sd),
        .SHIFT_CLOCK_IN(sck), .LATCH_CLOCK_IN(lck), .CLEAR_N(clr_n),
        .OUT_EN_N(oe_n), .UPDATE_HOLD(hold), .PAR_OUT(par), .PAR_OE(oe),
        .CASCADE_SERIAL_OUT(casc), .LATCH_READY(rdy));
    // Clock, 4 ns period
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One pin pulse, model update, compare outputs
    task automatic step(input int d, input logic s, input logic l);
        host.pulse(d[0], s, l);
        @(negedge mclk);
        if (l && hold && q.size() < 2) q.push_back(sr);
        else if (l && !hold) lat = sr;
        if (s && clr_n) sr = ((sr << 1) | d) & 32'hff;
        `CHK(casc, sr[7])
        `CHK(par, lat[7:0])
    endtask
    initial begin
        rst_n = 1'h0;
        hold = 1'h0;
        void'($urandom(32'hd26e));
        repeat (5) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        `CHK(par, LATCH_RST_VAL)
        `CHK(rdy, 1'h1)
        // Eight random bits, then a latch edge alone
        for (int i = 0; i < 8; i++) step($urandom % 2, 1'h1, 1'h0);
        step(0, 1'h0, 1'h1);
        `CHK(oe, '1)
        // Outputs float while shifting goes on
        host.pins(1'h1, 1'h1);
        @(negedge mclk);
        `CHK(oe, '0)
        `CHK(casc, sr[7])
        for (int i = 0; i < 4; i++) step($urandom % 2, 1'h1, 1'h0);
        host.pins(1'h1, 1'h0);
        // Clear zeroes stages, shifts ignored, latch kept
        host.pins(1'h0, 1'h0);
        sr = 0;
        step(1, 1'h1, 1'h0);
        host.pins(1'h1, 1'h0);
        step(0, 1'h0, 1'h1);
        // Tied clocks show contents one shift behind
        for (int i = 0; i < 6; i++) step($urandom % 2, 1'h1, 1'h1);
        // Held buffer takes two snapshots, drops the third
        @(posedge mclk) hold <= 1'h1;
        for (int i = 0; i < 3; i++) step($urandom % 2, 1'h1, 1'h1);
        `CHK(rdy, 1'h0)
        @(posedge mclk) hold <= 1'h0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        lat = q[1];
        `CHK(par, lat[7:0])
        `CHK(rdy, 1'h1)
        conclude();
    end
endmodule
`default_nettype wire
